// >>> core/ccp_pkg.sv
// Constants shared by the capture/compare/PWM unit and its period timer
//----------------------------------------------------------------------
// Summary of operation
// - Period timer clock prescaled by 1, 4 or 16
// - Prescale field: 00 /1, 01 /4, 1x /16
// - Period matches feed postscaler; terminal count sets flag
// - Postscale ratio equals field value plus one
// - Period timer counts only while on bit set
// - Count or control write clears pre/postscaler
// - Control write keeps count; reset clears count
// - Count up to period, then wrap, signal match
// - Period register resets to FFh
// - PWM uses period timer; capture/compare external count
// - Capture value reached as two byte halves
// - Outside PWM only output A serves unit
// - PWM configuration 00 steers A only, 10 steers A/B
// - PWM configurations 01 and 11 steer quad outputs
// - Bits 5-4 are duty LSBs in PWM only
// - Mode 0000 switches off and resets unit
// - Capture on fall, rise, 4th, 16th rise
// - Compare match toggles, sets or clears, flags
// - Mode 1010 match only sets flag
// - Mode 1011 flags, resets timer, starts conversion
// - Trigger reset never sets overflow flag
// - PWM codes; bit1 inverts A/C, bit0 B/D
// - Capture loads current external sixteen-bit count
// - Capture sets flag; only software clears it
// - Later capture overwrites unread earlier value
//----------------------------------------------------------------------
package ccp_pkg;
   // Bus geometry
   localparam int ADDR_W = 12;
   // Register indexes; byte address is four times the index
   localparam logic [7:0] IDX_GIC = 8'h0B;
   localparam logic [7:0] IDX_PIF = 8'h0C;
   localparam logic [7:0] IDX_PTC = 8'h11;
   localparam logic [7:0] IDX_PTCTL = 8'h12;
   localparam logic [7:0] IDX_CVL = 8'h15;
   localparam logic [7:0] IDX_CVH = 8'h16;
   localparam logic [7:0] IDX_CCPC = 8'h17;
   localparam logic [7:0] IDX_PIE = 8'h8C;
   localparam logic [7:0] IDX_PER = 8'h92;
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_PERIOD = 8'hFF;
   // Implemented-bit masks
   localparam logic [7:0] MASK_FLAGS = 8'h07;
   localparam logic [7:0] MASK_PTCTL = 8'h7F;
   // Flag / enable bit positions
   localparam int FLG_OVF = 0;
   localparam int FLG_PMF = 1;
   localparam int FLG_CCF = 2;
   // Period timer control fields
   localparam int PT_PRE_LO = 0;
   localparam int PT_PRE_HI = 1;
   localparam int PT_ON = 2;
   localparam int PT_POST_LO = 3;
   localparam int PT_POST_HI = 6;
   // Unit control fields
   localparam int CC_MODE_LO = 0;
   localparam int CC_MODE_HI = 3;
   localparam int CC_DC_LO = 4;
   localparam int CC_DC_HI = 5;
   localparam int CC_CONF_LO = 6;
   localparam int CC_CONF_HI = 7;
   // Unit mode codes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CMP_TGL = 4'h2;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_4 = 4'h6;
   localparam logic [3:0] MODE_CAP_16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
   localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
   localparam logic [1:0] GRP_CAPTURE = 2'h1;
   localparam logic [1:0] GRP_PWM = 2'h3;
   // Output configurations
   localparam logic [1:0] CONF_SINGLE = 2'h0;
   localparam logic [1:0] CONF_FWD = 2'h1;
   localparam logic [1:0] CONF_DUAL = 2'h2;
   localparam logic [1:0] CONF_REV = 2'h3;
   // Terminal counts of the capture edge counter
   localparam logic [3:0] CAP_TERM_4 = 4'h3;
   localparam logic [3:0] CAP_TERM_16 = 4'hF;
   // Terminal counts of the period prescaler
   localparam logic [3:0] PRE_TERM_1 = 4'h0;
   localparam logic [3:0] PRE_TERM_4 = 4'h3;
   localparam logic [3:0] PRE_TERM_16 = 4'hF;
endpackage

// >>> core/period_timer.sv
// Eight-bit period timer with prescaler and postscaler
`timescale 1ns/1ps
module period_timer import ccp_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic count_we,
   input wire logic [7:0] count_wdata,
   input wire logic ctrl_we,
   input wire logic timer_on,
   input wire logic [1:0] presc_sel,
   input wire logic [3:0] post_sel,
   input wire logic [7:0] period,
   output logic [7:0] count,
   output logic [1:0] fine,
   output logic period_match,
   output logic post_tick
);
   logic [7:0] cnt_ff, nxt_cnt; // Timer count
   logic [3:0] pre_ff, nxt_pre; // Prescale counter
   logic [3:0] post_ff, nxt_post; // Postscale counter
   logic match_ff, nxt_match; // Wrap pulse
   logic tick_ff, nxt_tick; // Postscaled pulse
   logic [3:0] pre_term; // Prescaler terminal count

   //------------------------------------------------------------
   // Next-state logic
   //------------------------------------------------------------
   always_comb begin
      // Divider select
      if (presc_sel[1]) begin
         pre_term = PRE_TERM_16;
      end else if (presc_sel[0]) begin
         pre_term = PRE_TERM_4;
      end else begin
         pre_term = PRE_TERM_1;
      end
      nxt_cnt = cnt_ff;
      nxt_pre = pre_ff;
      nxt_post = post_ff;
      nxt_match = 1'b0;
      nxt_tick = 1'b0;
      if (count_we || ctrl_we) begin
         // Either write restarts both scalers
         nxt_pre = '0;
         nxt_post = '0;
         if (count_we) begin
            nxt_cnt = count_wdata;
         end
      end else if (timer_on) begin
         if (pre_ff >= pre_term) begin
            nxt_pre = '0;
            if (cnt_ff == period) begin
               // Wrap after reaching period
               nxt_cnt = '0;
               nxt_match = 1'b1;
               if (post_ff >= post_sel) begin
                  nxt_post = '0;
                  nxt_tick = 1'b1;
               end else begin
                  nxt_post = post_ff + 4'h1;
               end
            end else begin
               nxt_cnt = cnt_ff + 8'h01;
            end
         end else begin
            nxt_pre = pre_ff + 4'h1;
         end
      end
   end

   //------------------------------------------------------------
   // State registers
   //------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= RST_ZERO;
         pre_ff <= '0;
         post_ff <= '0;
         match_ff <= 1'b0;
         tick_ff <= 1'b0;
      end else if (clk_en) begin
         cnt_ff <= nxt_cnt;
         pre_ff <= nxt_pre;
         post_ff <= nxt_post;
         match_ff <= nxt_match;
         tick_ff <= nxt_tick;
      end
   end

   assign count = cnt_ff;
   // Two fine bits extend the count for ten-bit duty
   assign fine = presc_sel[1] ? pre_ff[3:2] : pre_ff[1:0];
   assign period_match = match_ff;
   assign post_tick = tick_ff;
endmodule // period_timer

// >>> core/capture_compare_pwm_with_period_timer.sv
// Capture/compare/PWM unit with APB register file and period timer
`timescale 1ns/1ps
module capture_compare_pwm_with_period_timer import ccp_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] external_sixteen_bit_count,
   input wire logic long_timer_overflow,
   input wire logic adc_enabled,
   input wire logic capture_pin,
   output logic output_a,
   output logic output_b,
   output logic output_c,
   output logic output_d,
   output logic drive_a,
   output logic drive_b,
   output logic drive_c,
   output logic drive_d,
   output logic ext_timer_reset,
   output logic adc_start
);
   //------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------
   logic [31:0] prdata_ff, nxt_prdata; // Read data
   logic pready_ff, nxt_pready; // Access-phase ready
   logic pslverr_ff, nxt_pslverr; // Unmapped address
   logic [7:0] gic_ff, nxt_gic; // Global interrupt control
   logic [7:0] pif_ff, nxt_pif; // Peripheral flags
   logic [7:0] pie_ff, nxt_pie; // Peripheral enables
   logic [7:0] ptctl_ff, nxt_ptctl; // Period timer control
   logic [7:0] per_ff, nxt_per; // Period value
   logic [7:0] ccpc_ff, nxt_ccpc; // Unit control
   logic [15:0] cv_ff, nxt_cv; // Capture/compare/duty value
   logic [3:0] edge_ff, nxt_edge; // Capture edge counter
   logic eq_prev_ff, nxt_eq_prev; // Previous compare equality
   logic cmp_ff, nxt_cmp; // Compare output latch
   logic [9:0] duty_ff, nxt_duty; // Latched PWM duty
   logic pwm_ff, nxt_pwm; // PWM waveform
   logic trig_ff, nxt_trig; // Timer reset pulse
   logic adc_ff, nxt_adc; // Conversion start pulse
   logic [3:0] outs_ff, nxt_outs; // Pin levels D..A
   logic [3:0] own_ff, nxt_own; // Pin ownership D..A
   logic sync1_ff, sync2_ff, last_ff; // Capture pin synchroniser
   logic setup; // APB setup phase
   logic wr; // Completed write
   logic [7:0] wbyte; // Write byte
   logic [7:0] rbyte; // Read byte
   logic mapped; // Address decodes
   logic [3:0] mode; // Unit mode
   logic [1:0] conf; // Output configuration
   logic rise, fall; // Capture pin edges
   logic cap_ev; // Capture event
   logic cmp_mode; // Any compare mode
   logic eq_now; // Count equals value
   logic cmp_hit; // Compare match edge
   logic pwm_mode; // PWM selected
   logic [7:0] pt_count; // Period timer count
   logic [1:0] pt_fine; // Period timer fine bits
   logic pt_match; // Period wrap pulse
   logic pt_tick; // Postscaled pulse
   logic pt_count_we; // Count register write
   logic pt_ctrl_we; // Control register write

   // Decode one register index against the byte address
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction

   // Compare modes drive or flag output A
   function automatic logic is_cmp(input logic [3:0] m);
      is_cmp = (m == MODE_CMP_TGL) || (m[3:2] == 2'b10);
   endfunction

   //------------------------------------------------------------
   // Period timer
   //------------------------------------------------------------
   period_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .count_we(pt_count_we),
      .count_wdata(wbyte),
      .ctrl_we(pt_ctrl_we),
      .timer_on(ptctl_ff[PT_ON]),
      .presc_sel(ptctl_ff[PT_PRE_HI:PT_PRE_LO]),
      .post_sel(ptctl_ff[PT_POST_HI:PT_POST_LO]),
      .period(per_ff),
      .count(pt_count),
      .fine(pt_fine),
      .period_match(pt_match),
      .post_tick(pt_tick)
   );

   //------------------------------------------------------------
   // APB slave
   //------------------------------------------------------------
   assign setup = psel && !penable;
   assign wr = psel && penable && pready_ff && pwrite && !pslverr_ff;
   assign wbyte = pwdata[7:0];
   assign pt_count_we = wr && hit(paddr, IDX_PTC);
   assign pt_ctrl_we = wr && hit(paddr, IDX_PTCTL);

   // Read mux and address check
   always_comb begin
      rbyte = RST_ZERO;
      mapped = 1'b1;
      if (hit(paddr, IDX_GIC)) rbyte = gic_ff;
      else if (hit(paddr, IDX_PIF)) rbyte = pif_ff;
      else if (hit(paddr, IDX_PIE)) rbyte = pie_ff;
      else if (hit(paddr, IDX_PTC)) rbyte = pt_count;
      else if (hit(paddr, IDX_PTCTL)) rbyte = ptctl_ff;
      else if (hit(paddr, IDX_PER)) rbyte = per_ff;
      else if (hit(paddr, IDX_CCPC)) rbyte = ccpc_ff;
      else if (hit(paddr, IDX_CVL)) rbyte = cv_ff[7:0];
      else if (hit(paddr, IDX_CVH)) rbyte = cv_ff[15:8];
      else mapped = 1'b0;
   end

   // Ready, error and data are prepared in the setup phase
   always_comb begin
      nxt_pready = setup;
      nxt_pslverr = setup && !mapped;
      nxt_prdata = setup ? {24'h000000, rbyte} : prdata_ff;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (clk_en) begin
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   //------------------------------------------------------------
   // Capture pin synchroniser
   //------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         last_ff <= 1'b0;
      end else if (clk_en) begin
         sync1_ff <= capture_pin;
         sync2_ff <= sync1_ff;
         last_ff <= sync2_ff;
      end
   end

   assign rise = sync2_ff && !last_ff;
   assign fall = !sync2_ff && last_ff;
   assign mode = ccpc_ff[CC_MODE_HI:CC_MODE_LO];
   assign conf = ccpc_ff[CC_CONF_HI:CC_CONF_LO];
   assign pwm_mode = (mode[3:2] == GRP_PWM);
   assign cmp_mode = is_cmp(mode);
   assign eq_now = (external_sixteen_bit_count == cv_ff);
   assign cmp_hit = cmp_mode && eq_now && !eq_prev_ff;

   //------------------------------------------------------------
   // Registers, capture, compare and PWM next state
   //------------------------------------------------------------
   always_comb begin
      nxt_gic = gic_ff;
      nxt_pif = pif_ff;
      nxt_pie = pie_ff;
      nxt_ptctl = ptctl_ff;
      nxt_per = per_ff;
      nxt_ccpc = ccpc_ff;
      nxt_cv = cv_ff;
      nxt_edge = edge_ff;
      nxt_eq_prev = eq_now;
      nxt_cmp = cmp_ff;
      nxt_duty = duty_ff;
      nxt_pwm = pwm_ff;
      nxt_trig = 1'b0;
      nxt_adc = 1'b0;
      cap_ev = 1'b0;
      // Software writes
      if (wr) begin
         if (hit(paddr, IDX_GIC)) nxt_gic = wbyte;
         if (hit(paddr, IDX_PIF)) nxt_pif = wbyte & MASK_FLAGS;
         if (hit(paddr, IDX_PIE)) nxt_pie = wbyte & MASK_FLAGS;
         if (hit(paddr, IDX_PTCTL)) nxt_ptctl = wbyte & MASK_PTCTL;
         if (hit(paddr, IDX_PER)) nxt_per = wbyte;
         if (hit(paddr, IDX_CCPC)) nxt_ccpc = wbyte;
         if (hit(paddr, IDX_CVL)) nxt_cv[7:0] = wbyte;
         if (hit(paddr, IDX_CVH)) nxt_cv[15:8] = wbyte;
      end
      // Capture edge selection
      if (mode[3:2] != GRP_CAPTURE) begin
         nxt_edge = '0;
      end else begin
         case (mode)
            MODE_CAP_FALL: cap_ev = fall;
            MODE_CAP_RISE: cap_ev = rise;
            MODE_CAP_4: begin
               if (rise) begin
                  cap_ev = (edge_ff >= CAP_TERM_4);
                  nxt_edge = cap_ev ? 4'h0 : edge_ff + 4'h1;
               end
            end
            MODE_CAP_16: begin
               if (rise) begin
                  cap_ev = (edge_ff >= CAP_TERM_16);
                  nxt_edge = cap_ev ? 4'h0 : edge_ff + 4'h1;
               end
            end
            default: cap_ev = 1'b0;
         endcase
      end
      // Capture overwrites any unread value
      if (cap_ev) nxt_cv = external_sixteen_bit_count;
      // Compare actions on the first cycle of equality
      if (cmp_hit) begin
         case (mode)
            MODE_CMP_TGL: nxt_cmp = !cmp_ff;
            MODE_CMP_SET: nxt_cmp = 1'b1;
            MODE_CMP_CLR: nxt_cmp = 1'b0;
            MODE_CMP_TRIG: begin
               nxt_trig = 1'b1;
               nxt_adc = adc_enabled;
            end
            default: nxt_cmp = cmp_ff;
         endcase
      end
      // PWM waveform on the period timer base
      if (pwm_mode) begin
         if (pt_match) begin
            nxt_duty = {cv_ff[7:0], ccpc_ff[CC_DC_HI:CC_DC_LO]};
            nxt_pwm = (nxt_duty != 10'h000);
         end else if ({pt_count, pt_fine} == duty_ff) begin
            nxt_pwm = 1'b0;
         end
      end else begin
         nxt_pwm = 1'b0;
      end
      // Unit off clears its state
      if (mode == MODE_OFF) begin
         nxt_cmp = 1'b0;
         nxt_duty = '0;
      end
      // Hardware sets win over software writes
      if (cap_ev || cmp_hit) nxt_pif[FLG_CCF] = 1'b1;
      if (pt_tick) nxt_pif[FLG_PMF] = 1'b1;
      // Only the outside timer's own overflow sets its flag
      if (long_timer_overflow) nxt_pif[FLG_OVF] = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gic_ff <= RST_ZERO;
         pif_ff <= RST_ZERO;
         pie_ff <= RST_ZERO;
         ptctl_ff <= RST_ZERO;
         per_ff <= RST_PERIOD;
         ccpc_ff <= RST_ZERO;
         cv_ff <= 16'h0000;
         edge_ff <= 4'h0;
         eq_prev_ff <= 1'b0;
         cmp_ff <= 1'b0;
         duty_ff <= 10'h000;
         pwm_ff <= 1'b0;
         trig_ff <= 1'b0;
         adc_ff <= 1'b0;
      end else if (clk_en) begin
         gic_ff <= nxt_gic;
         pif_ff <= nxt_pif;
         pie_ff <= nxt_pie;
         ptctl_ff <= nxt_ptctl;
         per_ff <= nxt_per;
         ccpc_ff <= nxt_ccpc;
         cv_ff <= nxt_cv;
         edge_ff <= nxt_edge;
         eq_prev_ff <= nxt_eq_prev;
         cmp_ff <= nxt_cmp;
         duty_ff <= nxt_duty;
         pwm_ff <= nxt_pwm;
         trig_ff <= nxt_trig;
         adc_ff <= nxt_adc;
      end
   end

   //------------------------------------------------------------
   // Output steering
   //------------------------------------------------------------
   // Index 0..3 is A..D; A/C invert on mode bit 1, B/D on bit 0
   always_comb begin
      nxt_outs = 4'h0;
      nxt_own = 4'h0;
      if (pwm_mode) begin
         case (conf)
            CONF_SINGLE: begin
               nxt_own = 4'b0001;
               nxt_outs[0] = pwm_ff ^ mode[1];
            end
            CONF_FWD: begin
               nxt_own = 4'b1111;
               nxt_outs[0] = !mode[1];
               nxt_outs[1] = mode[0];
               nxt_outs[2] = mode[1];
               nxt_outs[3] = pwm_ff ^ mode[0];
            end
            CONF_DUAL: begin
               // Complementary pair; dead band not modelled
               nxt_own = 4'b0011;
               nxt_outs[0] = pwm_ff ^ mode[1];
               nxt_outs[1] = !pwm_ff ^ mode[0];
            end
            CONF_REV: begin
               nxt_own = 4'b1111;
               nxt_outs[0] = mode[1];
               nxt_outs[1] = pwm_ff ^ mode[0];
               nxt_outs[2] = !mode[1];
               nxt_outs[3] = mode[0];
            end
            default: nxt_own = 4'h0;
         endcase
      end else if (cmp_mode) begin
         // Only A carries the compare latch
         nxt_own = 4'b0001;
         nxt_outs[0] = cmp_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         outs_ff <= 4'h0;
         own_ff <= 4'h0;
      end else if (clk_en) begin
         outs_ff <= nxt_outs;
         own_ff <= nxt_own;
      end
   end

   //------------------------------------------------------------
   // Port drive
   //------------------------------------------------------------
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign output_a = outs_ff[0];
   assign output_b = outs_ff[1];
   assign output_c = outs_ff[2];
   assign output_d = outs_ff[3];
   assign drive_a = own_ff[0];
   assign drive_b = own_ff[1];
   assign drive_c = own_ff[2];
   assign drive_d = own_ff[3];
   assign ext_timer_reset = trig_ff;
   assign adc_start = adc_ff;
endmodule // capture_compare_pwm_with_period_timer

// >>> test/ccp_asserts.sv
// Port-level assertions of the capture/compare/PWM unit
`timescale 1ns/1ps
module ccp_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic drive_a,
   input wire logic drive_b,
   input wire logic drive_c,
   input wire logic drive_d,
   input wire logic ext_timer_reset,
   input wire logic adc_start
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   //----------------------------------------
   // Register bus answers
   //----------------------------------------
   wait_free_a: assert property (clk_en && psel && !penable |=> pready) else $error("late answer");
   ready_once_a: assert property (clk_en && pready |=> !pready) else $error("long answer");
   err_ready_a: assert property (pslverr |-> pready) else $error("error without answer");
   //----------------------------------------
   // Special event and pin ownership
   //----------------------------------------
   trig_once_a: assert property (ext_timer_reset |=> !ext_timer_reset) else $error("long trigger");
   adc_trig_a: assert property (adc_start |-> ext_timer_reset) else $error("stray conversion");
   b_needs_a_a: assert property (drive_b |-> drive_a) else $error("B without A");
   quad_all_a: assert property (drive_c |-> drive_a && drive_b && drive_d) else $error("partial quad");
   d_needs_c_a: assert property (drive_d |-> drive_c) else $error("D without C");
   cover property (ext_timer_reset);
   cover property (drive_d);
   cover property (pslverr);
endmodule // ccp_asserts
bind capture_compare_pwm_with_period_timer ccp_asserts i_ccp_asserts (.pclk, .presetn, .clk_en, .psel,
   .penable, .pready, .pslverr, .drive_a, .drive_b, .drive_c, .drive_d, .ext_timer_reset, .adc_start);

// >>> test/pin_partner.sv
// Model of the external sixteen-bit timer and the capture pin
`timescale 1ns/1ps
module pin_partner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic ext_timer_reset,
   output logic [15:0] count,
   output logic overflow,
   output logic pin
);
   initial pin = 1'h0;
   // Short wrap keeps compare matches close; the trigger clears without overflow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 16'h0000;
         overflow <= 1'h0;
      end else begin
         overflow <= run && !ext_timer_reset && count == 16'h003F;
         if (ext_timer_reset) count <= 16'h0000;
         else if (run) count <= (count == 16'h003F) ? 16'h0000 : count + 16'h0001;
      end
   end
   // Pin pulses, four cycles high then four low
   task automatic pulse(input int n);
      repeat (n) begin
         pin <= 1'h1;
         repeat (4) @(posedge pclk);
         pin <= 1'h0;
         repeat (4) @(posedge pclk);
      end
   endtask
endmodule // pin_partner

// >>> test/capture_compare_pwm_with_period_timer_tb.sv
// Self-checking bench of the capture/compare/PWM unit
`timescale 1ns/1ps
module capture_compare_pwm_with_period_timer_tb import ccp_pkg::*;;
   logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, adc_enabled = 1'h1, run = 1'h0, trig = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, e, long_timer_overflow, capture_pin;
   logic output_a, output_b, output_c, output_d, drive_a, drive_b, drive_c, drive_d, ext_timer_reset, adc_start;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic [15:0] external_sixteen_bit_count;
   int error_cnt = 0, comparisons = 0, cyc = 0;
   pin_partner i_pin_partner (.pclk, .presetn, .run, .ext_timer_reset, .count(external_sixteen_bit_count),
      .overflow(long_timer_overflow), .pin(capture_pin));
   capture_compare_pwm_with_period_timer i_capture_compare_pwm_with_period_timer (.pclk, .presetn, .clk_en,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_sixteen_bit_count,
      .long_timer_overflow, .adc_enabled, .capture_pin, .output_a, .output_b, .output_c, .output_d,
      .drive_a, .drive_b, .drive_c, .drive_d, .ext_timer_reset, .adc_start);
   // Clock, trigger watch and run limit
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (ext_timer_reset === 1'h1 && adc_start === 1'h1) trig <= 1'h1;
      if (cyc == 5000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic close_out;
      if (error_cnt == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (!ok) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // One bus transfer to a register index; answer left in q and e
   task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {2'h0, i, 2'h0};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1 && cyc < 5000);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [7:0] i, input logic [7:0] m, input logic [7:0] x, input string s);
      xfer(1'h0, i, 8'h00);
      chk((q[7:0] & m) === x && e === 1'h0, s);
   endtask
   task automatic t_reset;
      rdc(IDX_PER, 8'hFF, 8'hFF, "period reset");
      rdc(IDX_PTC, 8'hFF, 8'h00, "count reset");
      rdc(IDX_CCPC, 8'hFF, 8'h00, "control reset");
      xfer(1'h0, 8'h01, 8'h00);
      chk(e === 1'h1 && q === 32'h0, "unmapped");
   endtask
   // Period 3, prescale 4, postscale 2: flag near 32 cycles
   task automatic t_timer;
      xfer(1'h1, IDX_PTC, 8'h22);
      xfer(1'h1, IDX_PTCTL, 8'h08);
      rdc(IDX_PTC, 8'hFF, 8'h22, "count kept");
      xfer(1'h1, IDX_PER, 8'h03);
      xfer(1'h1, IDX_PTC, 8'h00);
      xfer(1'h1, IDX_PIF, 8'h00);
      xfer(1'h1, IDX_PTCTL, 8'h0D);
      repeat (20) @(posedge pclk);
      rdc(IDX_PIF, 8'h02, 8'h00, "early flag");
      repeat (16) @(posedge pclk);
      rdc(IDX_PIF, 8'h02, 8'h02, "late flag");
   endtask
   task automatic t_compare;
      logic [7:0] md [6] = '{8'h08, 8'h09, 8'h02, 8'h02, 8'h0A, 8'h0B};
      logic lv [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
      xfer(1'h1, IDX_CVL, 8'h10);
      xfer(1'h1, IDX_CVH, 8'h00);
      run <= 1'h1;
      for (int k = 0; k < 6; k++) begin
         xfer(1'h1, IDX_PIF, 8'h00);
         xfer(1'h1, IDX_CCPC, md[k]);
         do xfer(1'h0, IDX_PIF, 8'h00); while (q[2] !== 1'h1 && cyc < 5000);
         repeat (3) @(posedge pclk);
         chk(output_a === lv[k] && drive_a === 1'h1 && trig === (k == 5), "compare pin");
      end
   endtask
   // Freeze the timer, then capture it on each edge choice
   task automatic t_capture;
      logic [7:0] md [4] = '{8'h05, 8'h04, 8'h06, 8'h07};
      int n [4] = '{1, 1, 4, 16};
      for (int k = 0; k < 4; k++) begin
         run <= 1'h1;
         repeat (k + 3) @(posedge pclk);
         run <= 1'h0;
         xfer(1'h1, IDX_CCPC, MODE_OFF);
         xfer(1'h1, IDX_PIF, 8'h00);
         chk(drive_a === 1'h0 && output_a === 1'h0, "unit off");
         xfer(1'h1, IDX_CVH, 8'hA5);
         xfer(1'h1, IDX_CCPC, md[k]);
         i_pin_partner.pulse(n[k] - 1);
         rdc(IDX_PIF, 8'h04, 8'h00, "early capture");
         i_pin_partner.pulse(1);
         rdc(IDX_PIF, 8'h04, 8'h04, "capture flag");
         rdc(IDX_CVL, 8'hFF, external_sixteen_bit_count[7:0], "capture low");
         rdc(IDX_CVH, 8'hFF, external_sixteen_bit_count[15:8], "capture high");
      end
   endtask
   // Period 3 at prescale 1, duty 4: one cycle active in four, modes 1100 to 1111
   task automatic t_pwm;
      logic [3:0] dv [4] = '{4'h8, 4'hF, 4'hC, 4'hF};
      logic [3:0] hm [4] = '{4'h7, 4'hE, 4'h3, 4'hB};
      logic [3:0] hv [4] = '{4'h0, 4'hC, 4'h0, 4'h9};
      int ms [4] = '{3, 0, 3, 2};
      int na [4] = '{3, 9, 9, 9};
      logic [3:0] pv;
      int ones;
      xfer(1'h1, IDX_PER, 8'h03);
      xfer(1'h1, IDX_PTCTL, 8'h04);
      xfer(1'h1, IDX_CVL, 8'h01);
      for (int k = 0; k < 4; k++) begin
         xfer(1'h1, IDX_CCPC, {k[1:0], 4'h3, k[1:0]});
         repeat (3) @(posedge pclk);
         chk({drive_a, drive_b, drive_c, drive_d} === dv[k], "pin owners");
         ones = 0;
         repeat (12) begin
            @(posedge pclk);
            pv = {output_a, output_b, output_c, output_d};
            ones += int'(pv[ms[k]]);
         end
         chk(ones == na[k], "duty or polarity");
         chk((pv & hm[k]) === hv[k], "held pins");
      end
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_reset();
      t_timer();
      t_compare();
      t_capture();
      t_pwm();
      close_out();
   end
endmodule // capture_compare_pwm_with_period_timer_tb
